/* File: common/emop_pkg.sv */
// Constants, opcodes and register map of the extended memory-op datapath
// What this block does
// - Operand address reaches any memory section directly
// - Move copies working register, flags untouched
// - OR to working or memory, zero flag only
// - Rotate memory left, bit 7 into 0
// - Rotate-left result to working, memory kept
// - Nine-bit left rotate through link, to memory
// - Nine-bit left rotate through link, to working
// - Rotate memory right, bit 0 into 7
// - Rotate-right result to working, memory kept
// - Nine-bit right rotate through link, to memory
// - Nine-bit right rotate through link, to working
// - Subtract with borrow, six flags updated
// - Link cleared on negative, set otherwise
// - Plain subtract, same six flags
// - Taken skip adds dummy cycle, three total
// - Decrement memory, skip on zero, no flags
// - Decrement to working, skip on zero
// - Increment memory, skip on zero, no flags
// - Increment to working, skip on zero
// - Fill writes all ones, no flags
// - Bit set forces one selected bit
// - Bit test skips when bit is one
// - Byte test rewrites byte, skips when nonzero
`default_nettype none
package emop_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam int FLAGS_W = 6;
   // APB register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_WORK = 8'h04;
   localparam logic [7:0] OFF_FLAGS = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_MEM_ADDR = 8'h10;
   localparam logic [7:0] OFF_MEM_DATA = 8'h14;
   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BIT_LSB = 8;
   localparam int CMD_ADDR_LSB = 16;
   // Flag bit positions
   localparam int FLG_LINK = 0;
   localparam int FLG_NIBBLE = 1;
   localparam int FLG_ZERO = 2;
   localparam int FLG_OVR = 3;
   localparam int FLG_SCARRY = 4;
   localparam int FLG_CZERO = 5;
   // Status bit positions
   localparam int STS_BUSY = 0;
   localparam int STS_SKIP = 1;
   // Reset values and constants
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   // Opcodes
   localparam logic [4:0] OP_MOVE = 5'h00;
   localparam logic [4:0] OP_OR_W = 5'h01;
   localparam logic [4:0] OP_OR_M = 5'h02;
   localparam logic [4:0] OP_RL_M = 5'h03;
   localparam logic [4:0] OP_RL_W = 5'h04;
   localparam logic [4:0] OP_RLC_M = 5'h05;
   localparam logic [4:0] OP_RLC_W = 5'h06;
   localparam logic [4:0] OP_RR_M = 5'h07;
   localparam logic [4:0] OP_RR_W = 5'h08;
   localparam logic [4:0] OP_RRC_M = 5'h09;
   localparam logic [4:0] OP_RRC_W = 5'h0A;
   localparam logic [4:0] OP_SBC_W = 5'h0B;
   localparam logic [4:0] OP_SBC_M = 5'h0C;
   localparam logic [4:0] OP_SUB_W = 5'h0D;
   localparam logic [4:0] OP_SUB_M = 5'h0E;
   localparam logic [4:0] OP_DSZ_M = 5'h0F;
   localparam logic [4:0] OP_DSZ_W = 5'h10;
   localparam logic [4:0] OP_ISZ_M = 5'h11;
   localparam logic [4:0] OP_ISZ_W = 5'h12;
   localparam logic [4:0] OP_FILL = 5'h13;
   localparam logic [4:0] OP_BSET = 5'h14;
   localparam logic [4:0] OP_BTST_NZ = 5'h15;
   localparam logic [4:0] OP_SKIP_NZ = 5'h16;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FETCH = 4'h2,
      ST_EXEC = 4'h4,
      ST_DUMMY = 4'h8
   } state_e;
endpackage
`default_nettype wire

/* File: design/extended_memory_op_datapath.sv */
// Extended memory-op datapath with APB register access and local data memory
`default_nettype none
module extended_memory_op_datapath (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic op_busy,
   output logic skip_next
);
   emop_pkg::state_e state_r, state_nxt;
   logic [7:0] mem_r [emop_pkg::MEM_DEPTH];
   logic [7:0] work_r;
   logic [5:0] flags_r;
   logic [4:0] op_r;
   logic [7:0] addr_r;
   logic [2:0] bit_r;
   logic [7:0] operand_r;
   logic [7:0] sw_addr_r;
   logic last_skip_r;
   logic pready_r, pslverr_r, busy_r, skip_next_r;
   logic [31:0] prdata_r;
   logic acc_phase, xfer, wr_ok, cmd_go;
   logic [31:0] rd_data;
   logic rd_err;
   logic [7:0] res;
   logic [5:0] fl_nxt;
   logic wr_mem, wr_work, skip;
   logic [10:0] sb;
   logic borrow_form;

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   // Returns {overflow, nibble carry, carry, result}; carry high means no borrow
   function automatic logic [10:0] sub_calc(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
      logic [8:0] sum;
      logic [4:0] low;
      logic ov;
      sum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      ov = (a[7] ^ b[7]) & (sum[7] ^ a[7]);
      return {ov, low[4], sum[8], sum[7:0]};
   endfunction

   // APB: one wait state, answer registered
   assign acc_phase = psel & penable & ~pready_r;
   assign xfer = psel & penable & pready_r;
   assign wr_ok = xfer & pwrite & ~pslverr_r;
   assign cmd_go = wr_ok & (paddr[7:0] == emop_pkg::OFF_CMD);

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr[31:8] != 24'h00_0000) begin
         rd_err = 1'b1;
      end else begin
         case (paddr[7:0])
            emop_pkg::OFF_CMD: rd_data = {8'h00, addr_r, 5'h00, bit_r, 3'h0, op_r};
            emop_pkg::OFF_WORK: rd_data = {24'h00_0000, work_r};
            emop_pkg::OFF_FLAGS: rd_data = {26'h000_0000, flags_r};
            emop_pkg::OFF_STATUS: rd_data = {30'h0000_0000, last_skip_r, busy_r};
            emop_pkg::OFF_MEM_ADDR: rd_data = {24'h00_0000, sw_addr_r};
            emop_pkg::OFF_MEM_DATA: rd_data = {24'h00_0000, mem_r[sw_addr_r]};
            default: rd_err = 1'b1;
         endcase
      end
      // Writes while an operation runs would race the datapath
      if (pwrite && (busy_r || paddr[7:0] == emop_pkg::OFF_STATUS)) begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= acc_phase;
         pslverr_r <= acc_phase & rd_err;
         if (acc_phase && !pwrite) begin
            prdata_r <= rd_err ? 32'h0000_0000 : rd_data;
         end
      end
   end

   // Command capture; the full address needs no section select
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_r <= emop_pkg::OP_MOVE;
         addr_r <= 8'h00;
         bit_r <= 3'h0;
      end else if (cmd_go) begin
         op_r <= pwdata[emop_pkg::CMD_OP_LSB +: 5];
         addr_r <= pwdata[emop_pkg::CMD_ADDR_LSB +: emop_pkg::ADDR_W];
         bit_r <= pwdata[emop_pkg::CMD_BIT_LSB +: 3];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sw_addr_r <= 8'h00;
      end else if (wr_ok && paddr[7:0] == emop_pkg::OFF_MEM_ADDR) begin
         sw_addr_r <= pwdata[7:0];
      end
   end

   // Operation decode and result
   assign borrow_form = (op_r == emop_pkg::OP_SBC_W) || (op_r == emop_pkg::OP_SBC_M);
   assign sb = sub_calc(work_r, operand_r, borrow_form ? flags_r[emop_pkg::FLG_LINK] : 1'b1);

   always_comb begin
      res = operand_r;
      fl_nxt = flags_r;
      wr_mem = 1'b0;
      wr_work = 1'b0;
      skip = 1'b0;
      case (op_r)
         emop_pkg::OP_MOVE: begin
            res = work_r;
            wr_mem = 1'b1;
         end
         emop_pkg::OP_OR_W, emop_pkg::OP_OR_M: begin
            res = work_r | operand_r;
            wr_work = (op_r == emop_pkg::OP_OR_W);
            wr_mem = (op_r == emop_pkg::OP_OR_M);
            fl_nxt[emop_pkg::FLG_ZERO] = is_zero(res);
         end
         emop_pkg::OP_RL_M, emop_pkg::OP_RL_W: begin
            res = {operand_r[6:0], operand_r[7]};
            wr_mem = (op_r == emop_pkg::OP_RL_M);
            wr_work = (op_r == emop_pkg::OP_RL_W);
         end
         emop_pkg::OP_RLC_M, emop_pkg::OP_RLC_W: begin
            res = {operand_r[6:0], flags_r[emop_pkg::FLG_LINK]};
            fl_nxt[emop_pkg::FLG_LINK] = operand_r[7];
            wr_mem = (op_r == emop_pkg::OP_RLC_M);
            wr_work = (op_r == emop_pkg::OP_RLC_W);
         end
         emop_pkg::OP_RR_M, emop_pkg::OP_RR_W: begin
            res = {operand_r[0], operand_r[7:1]};
            wr_mem = (op_r == emop_pkg::OP_RR_M);
            wr_work = (op_r == emop_pkg::OP_RR_W);
         end
         emop_pkg::OP_RRC_M, emop_pkg::OP_RRC_W: begin
            res = {flags_r[emop_pkg::FLG_LINK], operand_r[7:1]};
            fl_nxt[emop_pkg::FLG_LINK] = operand_r[0];
            wr_mem = (op_r == emop_pkg::OP_RRC_M);
            wr_work = (op_r == emop_pkg::OP_RRC_W);
         end
         emop_pkg::OP_SBC_W, emop_pkg::OP_SBC_M, emop_pkg::OP_SUB_W, emop_pkg::OP_SUB_M: begin
            res = sb[7:0];
            wr_work = (op_r == emop_pkg::OP_SBC_W) || (op_r == emop_pkg::OP_SUB_W);
            wr_mem = (op_r == emop_pkg::OP_SBC_M) || (op_r == emop_pkg::OP_SUB_M);
            fl_nxt[emop_pkg::FLG_LINK] = sb[8];
            fl_nxt[emop_pkg::FLG_NIBBLE] = sb[9];
            fl_nxt[emop_pkg::FLG_OVR] = sb[10];
            fl_nxt[emop_pkg::FLG_SCARRY] = sb[10] ^ sb[7];
            fl_nxt[emop_pkg::FLG_ZERO] = is_zero(sb[7:0]);
            // Borrow forms chain the zero test across multi-byte words
            fl_nxt[emop_pkg::FLG_CZERO] = is_zero(sb[7:0]) &
               (borrow_form ? flags_r[emop_pkg::FLG_CZERO] : 1'b1);
         end
         emop_pkg::OP_DSZ_M, emop_pkg::OP_DSZ_W: begin
            res = operand_r - emop_pkg::BYTE_ONE;
            wr_mem = (op_r == emop_pkg::OP_DSZ_M);
            wr_work = (op_r == emop_pkg::OP_DSZ_W);
            skip = is_zero(res);
         end
         emop_pkg::OP_ISZ_M, emop_pkg::OP_ISZ_W: begin
            res = operand_r + emop_pkg::BYTE_ONE;
            wr_mem = (op_r == emop_pkg::OP_ISZ_M);
            wr_work = (op_r == emop_pkg::OP_ISZ_W);
            skip = is_zero(res);
         end
         emop_pkg::OP_FILL: begin
            res = emop_pkg::ALL_ONES;
            wr_mem = 1'b1;
         end
         emop_pkg::OP_BSET: begin
            res = operand_r | (emop_pkg::BYTE_ONE << bit_r);
            wr_mem = 1'b1;
         end
         emop_pkg::OP_BTST_NZ: begin
            skip = operand_r[bit_r];
         end
         emop_pkg::OP_SKIP_NZ: begin
            res = operand_r;
            wr_mem = 1'b1;
            skip = !is_zero(operand_r);
         end
         default: begin
            res = operand_r;
         end
      endcase
   end

   // Sequencer: fetch, execute, optional dummy cycle
   always_comb begin
      case (state_r)
         emop_pkg::ST_IDLE: state_nxt = cmd_go ? emop_pkg::ST_FETCH : emop_pkg::ST_IDLE;
         emop_pkg::ST_FETCH: state_nxt = emop_pkg::ST_EXEC;
         emop_pkg::ST_EXEC: state_nxt = skip ? emop_pkg::ST_DUMMY : emop_pkg::ST_IDLE;
         emop_pkg::ST_DUMMY: state_nxt = emop_pkg::ST_IDLE;
         default: state_nxt = emop_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= emop_pkg::ST_IDLE;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_r <= (state_nxt != emop_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         skip_next_r <= 1'b0;
         last_skip_r <= 1'b0;
      end else begin
         skip_next_r <= (state_r == emop_pkg::ST_EXEC) && skip;
         if (state_r == emop_pkg::ST_EXEC) begin
            last_skip_r <= skip;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         operand_r <= 8'h00;
      end else if (state_r == emop_pkg::ST_FETCH) begin
         operand_r <= mem_r[addr_r];
      end
   end

   // Software writes are refused while busy, so no port collision here
   always_ff @(posedge sys_clk) begin
      if (state_r == emop_pkg::ST_EXEC && wr_mem) begin
         mem_r[addr_r] <= res;
      end else if (wr_ok && paddr[7:0] == emop_pkg::OFF_MEM_DATA) begin
         mem_r[sw_addr_r] <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         work_r <= emop_pkg::WORK_RST;
      end else if (state_r == emop_pkg::ST_EXEC && wr_work) begin
         work_r <= res;
      end else if (wr_ok && paddr[7:0] == emop_pkg::OFF_WORK) begin
         work_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_r <= emop_pkg::FLAGS_RST;
      end else if (state_r == emop_pkg::ST_EXEC) begin
         flags_r <= fl_nxt;
      end else if (wr_ok && paddr[7:0] == emop_pkg::OFF_FLAGS) begin
         flags_r <= pwdata[5:0];
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign op_busy = busy_r;
   assign skip_next = skip_next_r;

   logic in_exec;
   assign in_exec = (state_r == emop_pkg::ST_EXEC);

   property p_move;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_MOVE |=>
         mem_r[addr_r] == $past(work_r) && flags_r == $past(flags_r);
   endproperty
   a_move: assert property (p_move) else $error("move result or flags wrong");

   property p_or_work;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_OR_W |=>
         work_r == ($past(work_r) | $past(operand_r)) &&
         flags_r[emop_pkg::FLG_ZERO] == (work_r == 8'h00) &&
         flags_r[emop_pkg::FLG_LINK] == $past(flags_r[emop_pkg::FLG_LINK]);
   endproperty
   a_or_work: assert property (p_or_work) else $error("or into working wrong");

   property p_rl_mem;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_RL_M |=>
         mem_r[addr_r] == {$past(operand_r[6:0]), $past(operand_r[7])} &&
         flags_r == $past(flags_r);
   endproperty
   a_rl_mem: assert property (p_rl_mem) else $error("rotate left memory wrong");

   property p_rlc_work;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_RLC_W |=>
         work_r == {$past(operand_r[6:0]), $past(flags_r[emop_pkg::FLG_LINK])} &&
         flags_r[emop_pkg::FLG_LINK] == $past(operand_r[7]);
   endproperty
   a_rlc_work: assert property (p_rlc_work) else $error("link rotate left wrong");

   property p_rrc_mem;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_RRC_M |=>
         mem_r[addr_r] == {$past(flags_r[emop_pkg::FLG_LINK]), $past(operand_r[7:1])} &&
         flags_r[emop_pkg::FLG_LINK] == $past(operand_r[0]);
   endproperty
   a_rrc_mem: assert property (p_rrc_mem) else $error("link rotate right wrong");

   property p_sub_link;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_SUB_W |=>
         flags_r[emop_pkg::FLG_LINK] == ($past(work_r) >= $past(operand_r)) &&
         work_r == $past(work_r) - $past(operand_r);
   endproperty
   a_sub_link: assert property (p_sub_link) else $error("subtract link wrong");

   property p_skip_len;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(busy_r) ##2 skip_next_r |-> busy_r ##1 !busy_r;
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip not three cycles");

   property p_dsz;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_DSZ_M |=>
         mem_r[addr_r] == $past(operand_r) - emop_pkg::BYTE_ONE &&
         skip_next_r == ($past(operand_r) == emop_pkg::BYTE_ONE) && flags_r == $past(flags_r);
   endproperty
   a_dsz: assert property (p_dsz) else $error("decrement skip wrong");

   property p_isz_work;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_ISZ_W |=>
         work_r == $past(operand_r) + emop_pkg::BYTE_ONE &&
         skip_next_r == ($past(operand_r) == emop_pkg::ALL_ONES);
   endproperty
   a_isz_work: assert property (p_isz_work) else $error("increment skip wrong");

   property p_fill;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_FILL |=> mem_r[addr_r] == emop_pkg::ALL_ONES;
   endproperty
   a_fill: assert property (p_fill) else $error("fill not all ones");

   property p_btst;
      @(posedge sys_clk) disable iff (!reset_n)
      in_exec && op_r == emop_pkg::OP_BTST_NZ |=> skip_next_r == $past(operand_r[bit_r]);
   endproperty
   a_btst: assert property (p_btst) else $error("bit test skip wrong");
endmodule // extended_memory_op_datapath
`default_nettype wire

/* File: dv/seq_model.sv */
// Instruction sequencer model: measures each op's length and skip request
`default_nettype none
module seq_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic op_busy,
   input wire logic skip_next,
   output logic [3:0] busy_len,
   output logic skip_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_r;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) busy_r <= 1'b0;
      else busy_r <= op_busy;
   end
   // Length held after the op ends so the bench can read it late
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) busy_len <= 4'h0;
      else if (op_busy && !busy_r) busy_len <= 4'h1;
      else if (op_busy) busy_len <= busy_len + 4'h1;
   end
   // A skip pulse means the next fetched word is dropped
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) skip_seen <= 1'b0;
      else if (op_busy && !busy_r) skip_seen <= 1'b0;
      else if (skip_next) skip_seen <= 1'b1;
   end
endmodule // seq_model
`default_nettype wire

/* File: dv/tb_extended_memory_op_datapath.sv */
// Self-checking bench for the extended memory-op datapath
`default_nettype none
module tb_extended_memory_op_datapath;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, op_busy, skip_next;
   logic skip_seen;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0] busy_len;
   logic [7:0] cur_addr;
   int err_total, n_tests;

   extended_memory_op_datapath extended_memory_op_datapath_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_busy(op_busy), .skip_next(skip_next));
   seq_model seq_model_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .op_busy(op_busy),
      .skip_next(skip_next), .busy_len(busy_len), .skip_seen(skip_seen));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_total++;
         $display("CHECK FAILED t=%0t bus timeout", $time);
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, {24'h000000, o}, d, r, e);
      cmp({31'h0, e}, 32'h0, "write refused");
   endtask

   task automatic rd_chk(input logic [7:0] o, input logic [31:0] x, input string s);
      logic [31:0] r;
      logic e;
      apb(1'b0, {24'h000000, o}, 32'h0, r, e);
      cmp(r, x, s);
      cmp({31'h0, e}, 32'h0, "read refused");
   endtask

   // Loads operands, runs one op, checks every visible result
   task automatic exec_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] w,
                          input logic [7:0] m, input logic [5:0] f, input logic [7:0] ew,
                          input logic [7:0] em, input logic [5:0] ef, input logic sk);
      int n;
      logic [31:0] r;
      logic e;
      cur_addr = cur_addr + 8'h35;
      wr(emop_pkg::OFF_MEM_ADDR, {24'h0, cur_addr});
      wr(emop_pkg::OFF_MEM_DATA, {24'h0, m});
      wr(emop_pkg::OFF_WORK, {24'h0, w});
      wr(emop_pkg::OFF_FLAGS, {26'h0, f});
      apb(1'b1, 32'h0, {8'h00, cur_addr, 5'h00, b, 3'h0, op}, r, e);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (op_busy !== 1'b0 && n < 16);
      cmp({31'h0, n >= 16}, 32'h0, "op timeout");
      if (n >= 16) end_sim();
      cmp({28'h0, busy_len}, sk ? 32'h3 : 32'h2, "op length");
      cmp({31'h0, skip_seen}, {31'h0, sk}, "skip");
      rd_chk(emop_pkg::OFF_WORK, {24'h0, ew}, "work");
      rd_chk(emop_pkg::OFF_MEM_DATA, {24'h0, em}, "mem");
      rd_chk(emop_pkg::OFF_FLAGS, {26'h0, ef}, "flags");
      rd_chk(emop_pkg::OFF_STATUS, {30'h0, sk, 1'b0}, "status");
   endtask

   // Flags packed {cz, sc, ov, z, nibble, link}, then the byte
   function automatic logic [13:0] sub_exp(logic [7:0] w, logic [7:0] m, logic [5:0] f,
                                           logic bf);
      logic [8:0] d;
      logic [4:0] dn;
      logic bw, z, ov;
      bw = bf & ~f[0];
      d = {1'b0, w} - {1'b0, m} - {8'h0, bw};
      dn = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, bw};
      z = (d[7:0] == 8'h00);
      ov = (w[7] != m[7]) && (d[7] != w[7]);
      return {z & (bf ? f[5] : 1'b1), ov ^ d[7], ov, z, ~dn[4], ~d[8], d[7:0]};
   endfunction

   task automatic sub_case(input logic [4:0] op, input logic bf, input logic tow,
                           input logic [7:0] w, input logic [7:0] m, input logic [5:0] f);
      logic [13:0] x;
      x = sub_exp(w, m, f, bf);
      exec_op(op, 3'h0, w, m, f, tow ? x[7:0] : w, tow ? m : x[7:0], x[13:8], 1'b0);
   endtask

   task t_reset;
      rd_chk(emop_pkg::OFF_WORK, 32'h0, "work reset");
      rd_chk(emop_pkg::OFF_FLAGS, 32'h0, "flags reset");
      $display("test reset done");
   endtask

   task t_move_or;
      exec_op(emop_pkg::OP_MOVE, 3'h0, 8'h5A, 8'h00, 6'h2A, 8'h5A, 8'h5A, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_OR_W, 3'h0, 8'h0F, 8'hF0, 6'h2E, 8'hFF, 8'hF0, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_OR_M, 3'h0, 8'h00, 8'h00, 6'h2A, 8'h00, 8'h00, 6'h2E, 1'b0);
      $display("test move and or done");
   endtask

   task t_rotate;
      exec_op(emop_pkg::OP_RL_M, 3'h0, 8'h11, 8'h81, 6'h2A, 8'h11, 8'h03, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_RL_W, 3'h0, 8'h11, 8'h81, 6'h2B, 8'h03, 8'h81, 6'h2B, 1'b0);
      exec_op(emop_pkg::OP_RLC_M, 3'h0, 8'h11, 8'h80, 6'h2A, 8'h11, 8'h00, 6'h2B, 1'b0);
      exec_op(emop_pkg::OP_RLC_W, 3'h0, 8'h11, 8'h01, 6'h2B, 8'h03, 8'h01, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_RR_M, 3'h0, 8'h11, 8'h81, 6'h2A, 8'h11, 8'hC0, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_RR_W, 3'h0, 8'h11, 8'h01, 6'h2B, 8'h80, 8'h01, 6'h2B, 1'b0);
      exec_op(emop_pkg::OP_RRC_M, 3'h0, 8'h11, 8'h01, 6'h2A, 8'h11, 8'h00, 6'h2B, 1'b0);
      exec_op(emop_pkg::OP_RRC_W, 3'h0, 8'h11, 8'h80, 6'h2B, 8'hC0, 8'h80, 6'h2A, 1'b0);
      $display("test rotate done");
   endtask

   task t_subtract;
      sub_case(emop_pkg::OP_SUB_W, 1'b0, 1'b1, 8'h10, 8'h20, 6'h2B);
      sub_case(emop_pkg::OP_SUB_M, 1'b0, 1'b0, 8'h20, 8'h20, 6'h00);
      sub_case(emop_pkg::OP_SBC_W, 1'b1, 1'b1, 8'h80, 8'h01, 6'h01);
      sub_case(emop_pkg::OP_SBC_M, 1'b1, 1'b0, 8'h00, 8'h00, 6'h20);
      sub_case(emop_pkg::OP_SBC_W, 1'b1, 1'b1, 8'h05, 8'h04, 6'h20);
      sub_case(emop_pkg::OP_SBC_M, 1'b1, 1'b0, 8'h05, 8'h04, 6'h00);
      $display("test subtract done");
   endtask

   task t_step_skip;
      exec_op(emop_pkg::OP_DSZ_M, 3'h0, 8'h11, 8'h01, 6'h2A, 8'h11, 8'h00, 6'h2A, 1'b1);
      exec_op(emop_pkg::OP_DSZ_M, 3'h0, 8'h11, 8'h00, 6'h2A, 8'h11, 8'hFF, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_DSZ_W, 3'h0, 8'h11, 8'h01, 6'h2A, 8'h00, 8'h01, 6'h2A, 1'b1);
      exec_op(emop_pkg::OP_ISZ_M, 3'h0, 8'h11, 8'hFF, 6'h2A, 8'h11, 8'h00, 6'h2A, 1'b1);
      exec_op(emop_pkg::OP_ISZ_W, 3'h0, 8'h11, 8'h05, 6'h2A, 8'h06, 8'h05, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_ISZ_W, 3'h0, 8'h11, 8'hFF, 6'h2A, 8'h00, 8'hFF, 6'h2A, 1'b1);
      $display("test step and skip done");
   endtask

   task t_set_test;
      exec_op(emop_pkg::OP_FILL, 3'h0, 8'h11, 8'h12, 6'h2A, 8'h11, 8'hFF, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_BSET, 3'h7, 8'h11, 8'h00, 6'h2A, 8'h11, 8'h80, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_BSET, 3'h2, 8'h11, 8'h5A, 6'h2A, 8'h11, 8'h5E, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_BTST_NZ, 3'h3, 8'h11, 8'h08, 6'h2A, 8'h11, 8'h08, 6'h2A, 1'b1);
      exec_op(emop_pkg::OP_BTST_NZ, 3'h3, 8'h11, 8'hF7, 6'h2A, 8'h11, 8'hF7, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_SKIP_NZ, 3'h0, 8'h11, 8'h00, 6'h2A, 8'h11, 8'h00, 6'h2A, 1'b0);
      exec_op(emop_pkg::OP_SKIP_NZ, 3'h0, 8'h11, 8'h40, 6'h2A, 8'h11, 8'h40, 6'h2A, 1'b1);
      $display("test set and test done");
   endtask

   // Refused writes must leave the working register alone
   task t_refuse;
      logic [31:0] r;
      logic e;
      wr(emop_pkg::OFF_WORK, 32'h0000003C);
      apb(1'b1, {24'h0, emop_pkg::OFF_STATUS}, 32'h00000003, r, e);
      cmp({31'h0, e}, 32'h1, "status write");
      apb(1'b1, 32'h00000018, 32'h00000055, r, e);
      cmp({31'h0, e}, 32'h1, "unmapped write");
      apb(1'b1, 32'h00000104, 32'h00000077, r, e);
      cmp({31'h0, e}, 32'h1, "high address write");
      // Taken skip keeps the block busy through the next access phase
      wr(emop_pkg::OFF_MEM_ADDR, 32'h00000000);
      wr(emop_pkg::OFF_MEM_DATA, 32'h00000001);
      wr(emop_pkg::OFF_CMD, {27'h0, emop_pkg::OP_BTST_NZ});
      apb(1'b1, {24'h0, emop_pkg::OFF_WORK}, 32'h00000066, r, e);
      cmp({31'h0, e}, 32'h1, "write while busy");
      rd_chk(emop_pkg::OFF_WORK, 32'h0000003C, "work after refusals");
      $display("test refuse done");
   endtask

   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      cur_addr = 8'h00;
      err_total = 0;
      n_tests = 0;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_move_or();
      t_rotate();
      t_subtract();
      t_step_skip();
      t_set_test();
      t_refuse();
      end_sim();
   end
endmodule // tb_extended_memory_op_datapath
`default_nettype wire
